// ---- dv/clk_ctrl_chk_asserts.sv ----
`timescale 1ns/1ps
module clk_ctrl_chk (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // bus strobe
   input  wire logic       write,
   // calibration input, clock and oscillator outputs
   input  wire logic [7:0] cal_trim_14mhz,
   input  wire logic       periph_clock_en,
   input  wire logic [2:0] osc_band,
   input  wire logic [7:0] osc_trim_value
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // edges since the last write or reset
   logic [2:0] quiet;
   always_ff @(posedge clk)
      if (!rst_b || write) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
   // first edge after reset release
   sequence s_rel; $rose(rst_b); endsequence
   property p_rst_band; s_rel |-> osc_band == 3'h3; endproperty
   property p_en_rst; s_rel |-> periph_clock_en [*2]; endproperty
   property p_trim_nom; s_rel |-> osc_trim_value == 8'h80; endproperty
   property p_cal; s_rel |-> ##[1:3] osc_trim_value == cal_trim_14mhz; endproperty
   property p_glitch; $changed(osc_band) |=> $stable(osc_band); endproperty
   property p_band_cause; $changed(osc_band) |-> quiet < 3'h5; endproperty
   property p_trim_cause; $changed(osc_trim_value) |-> quiet < 3'h5; endproperty
   a_rst_band: assert property (p_rst_band) else $error("band reset wrong");
   a_en_rst: assert property (p_en_rst) else $error("clock not running");
   a_trim_nom: assert property (p_trim_nom) else $error("trim reset wrong");
   a_cal: assert property (p_cal) else $error("trim not calibrated");
   a_glitch: assert property (p_glitch) else $error("band glitch");
   a_band_cause: assert property (p_band_cause) else $error("band moved");
   a_trim_cause: assert property (p_trim_cause) else $error("trim moved");
endmodule
bind periph_clock_and_rc_osc_ctrl clk_ctrl_chk u_chk (.clk(clk), .rst_b(rst_b), .write(write),
   .cal_trim_14mhz(cal_trim_14mhz), .periph_clock_en(periph_clock_en),
   .osc_band(osc_band), .osc_trim_value(osc_trim_value));

// ---- dv/periph_clock_and_rc_osc_ctrl_tb.sv ----
`timescale 1ns/1ps
module periph_clock_and_rc_osc_ctrl_tb;
   logic        clk, rst_b, read, write, waitrequest, periph_clock_en, osc_band_reserved;
   logic [3:0]  address, byteenable;
   logic [31:0] writedata, readdata;
   logic [7:0]  cal_trim_14mhz, osc_trim_value, trim;
   logic [2:0]  osc_band;
   logic [1:0]  response;
   logic [33:0] q[$];
   int          failures, n_tests, cnt;
   periph_clock_and_rc_osc_ctrl dut (
      .clk               (clk),
      .rst_b             (rst_b),
      .address           (address),
      .read              (read),
      .write             (write),
      .writedata         (writedata),
      .byteenable        (byteenable),
      .readdata          (readdata),
      .waitrequest       (waitrequest),
      .response          (response),
      .cal_trim_14mhz    (cal_trim_14mhz),
      .periph_clock_en   (periph_clock_en),
      .osc_band          (osc_band),
      .osc_trim_value    (osc_trim_value),
      .osc_band_reserved (osc_band_reserved)
   );
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [33:0] g, e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one bus cycle, held until waitrequest is low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      read      <= !w;
      write     <= w;
      address   <= a;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         failures++;
         close_out;
      end
      read  <= 1'b0;
      write <= 1'b0;
   endtask
   // read with expected response and data noted
   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   // answered reads against the oldest note
   always @(posedge clk)
      if (read === 1'b1 && waitrequest === 1'b0) chk({response, readdata}, q.pop_front());
   // pulses of the peripheral clock over 1024 cycles
   task automatic pulses(input logic [31:0] d, input int e);
      bus(1'b1, 4'h8, d);
      repeat (600) @(posedge clk);
      cnt = 0;
      repeat (1024) begin
         @(posedge clk);
         cnt += int'(periph_clock_en);
      end
      chk(34'(cnt), 34'(e));
   endtask
   initial begin
      void'($urandom(32'hC03AC95A));
      {rst_b, read, write, address, writedata, byteenable} = {39'h0, 4'hF};
      cal_trim_14mhz = 8'($urandom);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(4'h8, 34'h100);
      rd(4'hC, {26'h3, cal_trim_14mhz});
      rd(4'h4, 34'h200000000);
      bus(1'b1, 4'h0, 32'h1FF);
      rd(4'h8, 34'h100);
      for (int c = 0; c < 10; c++) pulses(32'h100 | c, 1024 >> c);
      rd(4'h8, 34'h109);
      pulses(32'h0, 0);
      for (int b = 0; b < 8; b++) begin
         trim = 8'($urandom);
         bus(1'b1, 4'hC, {21'h0, 3'(b), trim});
         repeat (4) @(posedge clk);
         chk({osc_band_reserved, osc_band, osc_trim_value}, {b > 4, 3'(b), trim});
         rd(4'hC, {21'h0, 3'(b), trim});
      end
      close_out;
   end
endmodule

// ---- hw/clk_ctrl_pkg.sv ----
package clk_ctrl_pkg;
   // register byte offsets
   localparam logic [3:0] periph_div_offset   = 4'h8;
   localparam logic [3:0] rc_osc_ctrl_offset  = 4'hC;
   // peripheral divide register fields
   localparam int         div_lsb             = 0;
   localparam int         div_msb             = 3;
   localparam int         gate_bit            = 8;
   localparam logic [3:0] div_reset           = 4'h0;
   localparam logic       gate_reset          = 1'b1;
   localparam logic [3:0] div_max_code        = 4'h9;
   // oscillator control register fields
   localparam int         trim_lsb            = 0;
   localparam int         trim_msb            = 7;
   localparam int         band_lsb            = 8;
   localparam int         band_msb            = 10;
   localparam int         sud_lsb             = 12;
   localparam int         sud_msb             = 16;
   localparam logic [2:0] band_reset          = 3'h3;
   localparam logic [4:0] sud_reset           = 5'h00;
   localparam logic [7:0] trim_nominal        = 8'h80;
   // band codes
   localparam logic [2:0] band_1mhz           = 3'h0;
   localparam logic [2:0] band_7mhz           = 3'h1;
   localparam logic [2:0] band_11mhz          = 3'h2;
   localparam logic [2:0] band_14mhz          = 3'h3;
   localparam logic [2:0] band_21mhz          = 3'h4;
endpackage

// ---- hw/periph_clock_and_rc_osc_ctrl.sv ----
// Functional notes
// - divider code n (0..9) gives main clock divided by 2 to the n, reset code 0.
// - the three-bit band field picks 1, 7, 11, 14 or 21 MHz and resets to 3.
// - a band change glitches the oscillator output only when a second band change is written two edges after it.
// - a larger trim value gives a higher frequency, nominal reset 0x80.
// - on the first edge after reset release the trim field loads the 14 MHz production calibration value.
`timescale 1ns/1ps
module periph_clock_and_rc_osc_ctrl (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic [1:0]       response,
   // calibration value for the 14 MHz band
   input  wire logic [7:0]  cal_trim_14mhz,
   // peripheral clock enable pulse
   output logic             periph_clock_en,
   // oscillator control
   output logic [2:0]       osc_band,
   output logic [7:0]       osc_trim_value,
   output logic             osc_band_reserved
);

   logic [3:0] periph_clock_divider;
   logic       periph_clock_gate;
   logic [2:0] band_field;
   logic [4:0] startup_delay_field;
   logic [7:0] trim_field;
   logic       ack;
   logic       in_reset;
   logic [8:0] div_count;
   logic [8:0] div_mask;
   logic       hit_div;
   logic       hit_osc;
   logic       band_pending;
   logic [2:0] band_sync;
   logic [7:0] trim_sync;

   // address decode
   assign hit_div = (address == clk_ctrl_pkg::periph_div_offset);
   assign hit_osc = (address == clk_ctrl_pkg::rc_osc_ctrl_offset);

   // one wait cycle, accepted on the second edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack <= 1'b0;
      end else begin
         ack <= (read || write) && !ack;
      end
   end
   assign waitrequest = (read || write) && !ack;

   // read data and response
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         readdata <= 32'h00000000;
         response <= 2'h0;
      end else if ((read || write) && !ack) begin
         response <= (hit_div || hit_osc) ? 2'h0 : 2'h2;
         if (hit_div) begin
            readdata <= {23'h000000, periph_clock_gate, 4'h0, periph_clock_divider};
         end else if (hit_osc) begin
            readdata <= {15'h0000, startup_delay_field, 1'b0, band_field, trim_field};
         end else begin
            readdata <= 32'h00000000;
         end
      end
   end

   // peripheral divide register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         periph_clock_divider <= clk_ctrl_pkg::div_reset;
         periph_clock_gate    <= clk_ctrl_pkg::gate_reset;
      end else if (write && ack && hit_div) begin
         if (byteenable[0]) begin
            periph_clock_divider <= writedata[clk_ctrl_pkg::div_msb:clk_ctrl_pkg::div_lsb];
         end
         if (byteenable[1]) begin
            periph_clock_gate <= writedata[clk_ctrl_pkg::gate_bit];
         end
      end
   end

   // oscillator control register, trim loaded from calibration on the first edge after reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         band_field          <= clk_ctrl_pkg::band_reset;
         startup_delay_field <= clk_ctrl_pkg::sud_reset;
         trim_field          <= clk_ctrl_pkg::trim_nominal;
         in_reset            <= 1'b1;
      end else begin
         in_reset <= 1'b0;
         if (in_reset) begin
            trim_field <= cal_trim_14mhz;
         end else if (write && ack && hit_osc) begin
            if (byteenable[0]) begin
               trim_field <= writedata[clk_ctrl_pkg::trim_msb:clk_ctrl_pkg::trim_lsb];
            end
            if (byteenable[1]) begin
               band_field <= writedata[clk_ctrl_pkg::band_msb:clk_ctrl_pkg::band_lsb];
            end
            if (byteenable[1] && byteenable[2]) begin
               startup_delay_field <= writedata[clk_ctrl_pkg::sud_msb:clk_ctrl_pkg::sud_lsb];
            end
         end
      end
   end

   // divider mask: 2^code - 1, codes above 9 clamp to 511, a divide by 512
   always_comb begin
      if (periph_clock_divider > clk_ctrl_pkg::div_max_code) begin
         div_mask = 9'h1FF;
      end else begin
         div_mask = 9'((10'h001 << periph_clock_divider) - 10'h001);
      end
   end

   // free running prescaler
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_count <= 9'h000;
      end else if ((div_count & div_mask) == div_mask) begin
         div_count <= 9'h000;
      end else begin
         div_count <= div_count + 9'h001;
      end
   end

   // gated enable, one pulse each divided period
   assign periph_clock_en = periph_clock_gate && ((div_count & div_mask) == div_mask);

   // band and trim retimed together, a band change passed on two edges after it is seen, or one edge if written on the edge that passes the last one
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         band_pending <= 1'b0;
         band_sync    <= clk_ctrl_pkg::band_reset;
         trim_sync    <= clk_ctrl_pkg::trim_nominal;
      end else begin
         band_pending <= (band_field != band_sync);
         if (band_pending || (band_field == band_sync)) begin
            band_sync <= band_field;
            trim_sync <= trim_field;
         end
      end
   end

   // outputs toward the oscillator
   assign osc_band          = band_sync;
   assign osc_trim_value    = trim_sync;
   assign osc_band_reserved = (band_sync > clk_ctrl_pkg::band_21mhz);

endmodule
